// ---- rtl/psc_debounce.sv ----
// Synchroniser and debouncer for a group of switch inputs.
`timescale 1ns/1ps
module psc_debounce #(
	parameter int WIDTH = 4,
	parameter int STABLE_CYC = psc_pkg::DEBOUNCE_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] clean
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] last_r;
	logic [31:0] cnt_r;

	// Two-stage synchroniser; the first stage feeds only the second.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= raw;
			sync_r <= meta_r;
		end
	end

	// The output follows only after the input has held still for the full window.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			last_r <= '0;
			cnt_r <= '0;
			clean <= '0;
		end else begin
			last_r <= sync_r;
			if (sync_r != last_r) begin
				cnt_r <= '0;
			end else if (cnt_r < 32'(STABLE_CYC - 1)) begin
				cnt_r <= cnt_r + 32'h1;
			end else begin
				clean <= last_r;
			end
		end
	end
endmodule // psc_debounce

// ---- rtl/psc_panel.sv ----
// Panel switch decode, serial framing selection and status indicators.
// Function
// - Ready indicator lit only after all power-up diagnostics pass.
// - Run indicator lit while controller is started and solving logic.
// - Battery-low indicator lit when battery is depleted or absent.
// - Serial indicator lit when either serial port carries traffic.
// - Network indicator lit when the network port carries traffic.
// - Network error indicator lit on a network communication error.
// - Write-protect indicator lit while memory protect switch protects.
// - Fatal error blinks run indicator 2 to 8 times; kernel mode blinks continuously.
// - Address test failure gives five blinks, data test failure six blinks.
// - Left switch protects memory only in its top position.
// - Right switch selects how serial port parameters are determined.
// - Fixed ASCII or RTU modes default to network bridge mode.
// - Top position: ASCII, 2400 baud, even parity, 7 data, 1 stop.
// - Middle position: RTU, 9600 baud, even parity, 8 data, 1 stop.
// - Fixed modes take station address from the rotary switches.
// - Bottom position: software sets parity, data bits and stop bits.
// - Software mode accepts listed baud rates and addresses 1 to 247.
// - Rotary switches set network node and serial port address.
// - Upper rotary gives tens digit, lower rotary gives ones digit.
// - Highest valid switch address is 64; tens six allows ones 0 to 4.
// - Address 0 or above 64 holds network indicator steadily on.
`timescale 1ns/1ps
module psc_panel #(
	parameter int DEBOUNCE_CYC = psc_pkg::DEBOUNCE_CYC,
	parameter int BLINK_ON_CYC = psc_pkg::BLINK_ON_CYC,
	parameter int BLINK_PAUSE_CYC = psc_pkg::BLINK_PAUSE_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [1:0] protect_slide,
	input wire logic [1:0] comm_slide,
	input wire logic [3:0] address_tens_switch,
	input wire logic [3:0] address_ones_switch,
	input wire logic diag_passed,
	input wire logic ctrl_running,
	input wire logic battery_low,
	input wire logic serial1_active,
	input wire logic serial2_active,
	input wire logic net_active,
	input wire logic net_error,
	input wire logic fatal_error,
	input wire logic [3:0] fatal_blinks,
	input wire logic kernel_mode,
	input wire logic mem_addr_fail,
	input wire logic mem_data_fail,
	input wire logic soft_parity_en,
	input wire logic soft_parity_odd,
	input wire logic soft_data8,
	input wire logic soft_stop2,
	input wire logic [3:0] soft_baud,
	input wire logic [7:0] soft_addr,
	output logic led_ready,
	output logic led_run,
	output logic led_battery,
	output logic led_serial,
	output logic led_net,
	output logic led_net_error,
	output logic led_protect,
	output logic mem_protect,
	output logic [1:0] port_mode,
	output logic bridge_mode,
	output logic [3:0] port_baud,
	output logic port_parity_en,
	output logic port_parity_odd,
	output logic port_data8,
	output logic port_stop2,
	output logic [7:0] port_addr,
	output logic [6:0] node_addr,
	output logic addr_invalid,
	output logic soft_cfg_reject,
	output logic [15:0] error_code
);
	logic [11:0] sw_clean;
	logic [1:0] prot_sw;
	logic [1:0] comm_sw;
	logic [3:0] tens_sw;
	logic [3:0] ones_sw;
	logic [6:0] addr_dec;
	logic digits_ok;
	logic range_ok;
	logic addr_ok;
	logic soft_ok;
	logic any_source;
	logic on_done;
	logic pause_done;
	logic [3:0] blinks_sel;
	logic blinking;
	logic blink_led;
	logic [31:0] tmr_r;
	logic [3:0] blink_cnt_r;
	logic [15:0] code_nxt;

	typedef enum logic [1:0] {
		BL_IDLE, BL_ON, BL_OFF, BL_PAUSE
	} psc_blink_t;
	psc_blink_t blink_r;
	psc_pkg::psc_mode_t mode_sel;

	// Digit-pair to binary conversion, used for the validity check and both addresses.
	function automatic logic [6:0] psc_addr_of(input logic [3:0] tens, input logic [3:0] ones);
		logic [6:0] t;
		t = {3'h0, tens};
		psc_addr_of = 7'((t << 3) + (t << 1) + {3'h0, ones});
	endfunction

	// All switch inputs pass through one debouncer before any decode.
	psc_debounce #(
		.WIDTH(12),
		.STABLE_CYC(DEBOUNCE_CYC)
	) u_debounce (
		.mclk(mclk),
		.rst(rst),
		.raw({protect_slide, comm_slide, address_tens_switch, address_ones_switch}),
		.clean(sw_clean)
	);

	assign prot_sw = sw_clean[11:10];
	assign comm_sw = sw_clean[9:8];
	assign tens_sw = sw_clean[7:4];
	assign ones_sw = sw_clean[3:0];
	assign addr_dec = psc_addr_of(tens_sw, ones_sw);

	// A digit above nine or a value outside 1 to 64 is invalid.
	assign digits_ok = (ones_sw <= psc_pkg::DIGIT_MAX) && (tens_sw < psc_pkg::TENS_LAST
		|| (tens_sw == psc_pkg::TENS_LAST && ones_sw <= psc_pkg::ONES_LAST_AT_TOP));
	assign range_ok = (addr_dec != 7'h00) && (addr_dec <= psc_pkg::ADDR_MAX);
	assign addr_ok = digits_ok && range_ok;

	// The baud enum covers exactly the listed set, so only the address limits apply.
	assign soft_ok = (soft_addr >= psc_pkg::SW_ADDR_MIN) && (soft_addr <= psc_pkg::SW_ADDR_MAX);

	// Right slide decode; the unused fourth code behaves as the bottom position.
	always_comb begin
		unique case (comm_sw)
			psc_pkg::SLIDE_TOP: mode_sel = psc_pkg::MODE_ASCII;
			psc_pkg::SLIDE_MID: mode_sel = psc_pkg::MODE_RTU;
			default: mode_sel = psc_pkg::MODE_SOFT;
		endcase
	end

	// Plain status indicators.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			led_ready <= 1'b0;
			led_battery <= 1'b0;
			led_serial <= 1'b0;
			led_net_error <= 1'b0;
			led_net <= 1'b0;
		end else begin
			led_ready <= diag_passed;
			led_battery <= battery_low;
			led_serial <= serial1_active | serial2_active;
			led_net_error <= net_error;
			led_net <= net_active | ~addr_ok;
		end
	end

	// Write protection follows the left slide switch.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mem_protect <= 1'b0;
			led_protect <= 1'b0;
		end else begin
			mem_protect <= (prot_sw == psc_pkg::SLIDE_TOP);
			led_protect <= (prot_sw == psc_pkg::SLIDE_TOP);
		end
	end

	// Address outputs follow the rotary switches continuously.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			node_addr <= 7'h00;
			addr_invalid <= 1'b0;
		end else begin
			node_addr <= addr_ok ? addr_dec : 7'h00;
			addr_invalid <= ~addr_ok;
		end
	end

	// Serial port framing chosen by the right slide switch.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			port_mode <= psc_pkg::MODE_ASCII;
			bridge_mode <= 1'b0;
			port_baud <= psc_pkg::BAUD_2400;
			port_parity_en <= 1'b1;
			port_parity_odd <= 1'b0;
			port_data8 <= 1'b0;
			port_stop2 <= 1'b0;
			port_addr <= 8'h00;
		end else begin
			unique case (mode_sel)
				psc_pkg::MODE_ASCII: begin
					port_mode <= psc_pkg::MODE_ASCII;
					bridge_mode <= 1'b1;
					port_baud <= psc_pkg::BAUD_2400;
					port_parity_en <= 1'b1;
					port_parity_odd <= 1'b0;
					port_data8 <= 1'b0;
					port_stop2 <= 1'b0;
					port_addr <= {1'b0, node_addr};
				end
				psc_pkg::MODE_RTU: begin
					port_mode <= psc_pkg::MODE_RTU;
					bridge_mode <= 1'b1;
					port_baud <= psc_pkg::BAUD_9600;
					port_parity_en <= 1'b1;
					port_parity_odd <= 1'b0;
					port_data8 <= 1'b1;
					port_stop2 <= 1'b0;
					port_addr <= {1'b0, node_addr};
				end
				psc_pkg::MODE_SOFT: begin
					port_mode <= psc_pkg::MODE_SOFT;
					bridge_mode <= 1'b0;
					if (soft_ok) begin
						port_baud <= soft_baud;
						port_parity_en <= soft_parity_en;
						port_parity_odd <= soft_parity_odd;
						port_data8 <= soft_data8;
						port_stop2 <= soft_stop2;
						port_addr <= soft_addr;
					end
				end
			endcase
		end
	end

	// A software setting outside the accepted range is flagged and not applied.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			soft_cfg_reject <= 1'b0;
		end else begin
			soft_cfg_reject <= (mode_sel == psc_pkg::MODE_SOFT) && !soft_ok;
		end
	end

	// Blink count and code selection; memory test failures take precedence.
	always_comb begin
		blinks_sel = fatal_blinks;
		code_nxt = 16'h0000;
		if (mem_addr_fail) begin
			blinks_sel = psc_pkg::BLINKS_ADDR_TEST;
			code_nxt = psc_pkg::CODE_ADDR_TEST;
		end else if (mem_data_fail) begin
			blinks_sel = psc_pkg::BLINKS_DATA_TEST;
			code_nxt = psc_pkg::CODE_DATA_TEST;
		end else if (kernel_mode) begin
			code_nxt = psc_pkg::CODE_KERNEL;
		end
		if (blinks_sel < psc_pkg::BLINKS_MIN) begin
			blinks_sel = psc_pkg::BLINKS_MIN;
		end else if (blinks_sel > psc_pkg::BLINKS_MAX) begin
			blinks_sel = psc_pkg::BLINKS_MAX;
		end
	end

	assign blinking = fatal_error | mem_addr_fail | mem_data_fail;
	assign any_source = blinking | kernel_mode;
	assign on_done = (tmr_r >= 32'(BLINK_ON_CYC - 1));
	assign pause_done = (tmr_r >= 32'(BLINK_PAUSE_CYC - 1));

	// Blink sequencer: counted groups, each followed by a dark pause; kernel mode alone blinks on without any pause.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			blink_r <= BL_IDLE;
			tmr_r <= 32'h0;
			blink_cnt_r <= 4'h0;
		end else begin
			unique case (blink_r)
				BL_IDLE: begin
					tmr_r <= 32'h0;
					blink_cnt_r <= 4'h0;
					if (any_source) begin
						blink_r <= BL_ON;
					end
				end
				BL_ON: begin
					if (on_done) begin
						tmr_r <= 32'h0;
						blink_cnt_r <= blink_cnt_r + 4'h1;
						blink_r <= BL_OFF;
					end else begin
						tmr_r <= tmr_r + 32'h1;
					end
				end
				BL_OFF: begin
					if (on_done) begin
						tmr_r <= 32'h0;
						if (!any_source) begin
							blink_r <= BL_IDLE;
						end else if (!blinking) begin
							blink_r <= BL_ON;
						end else if (blink_cnt_r >= blinks_sel) begin
							blink_r <= BL_PAUSE;
						end else begin
							blink_r <= BL_ON;
						end
					end else begin
						tmr_r <= tmr_r + 32'h1;
					end
				end
				BL_PAUSE: begin
					blink_cnt_r <= 4'h0;
					if (pause_done) begin
						tmr_r <= 32'h0;
						blink_r <= any_source ? BL_ON : BL_IDLE;
					end else begin
						tmr_r <= tmr_r + 32'h1;
					end
				end
			endcase
		end
	end

	assign blink_led = (blink_r == BL_ON);

	// Run indicator: blink pattern overrides the steady running state.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			led_run <= 1'b0;
		end else begin
			if (any_source || blink_r != BL_IDLE) begin
				led_run <= blink_led;
			end else begin
				led_run <= ctrl_running;
			end
		end
	end

	// The error code register follows the highest-priority active source.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			error_code <= 16'h0000;
		end else begin
			error_code <= code_nxt;
		end
	end
endmodule // psc_panel

// ---- rtl/psc_pkg.sv ----
// Shared constants and types for the panel switch and indicator block.
package psc_pkg;
	localparam int CLK_HZ = 100000000;
	localparam int DEBOUNCE_MS = 10;
	localparam int DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
	localparam int BLINK_ON_MS = 250;
	localparam int BLINK_ON_CYC = (CLK_HZ / 1000) * BLINK_ON_MS;
	localparam int BLINK_PAUSE_MS = 1500;
	localparam int BLINK_PAUSE_CYC = (CLK_HZ / 1000) * BLINK_PAUSE_MS;
	localparam logic [1:0] SLIDE_TOP = 2'h0;
	localparam logic [1:0] SLIDE_MID = 2'h1;
	localparam logic [1:0] SLIDE_BOT = 2'h2;
	localparam logic [6:0] ADDR_MAX = 7'h40;
	localparam logic [3:0] TENS_LAST = 4'h6;
	localparam logic [3:0] ONES_LAST_AT_TOP = 4'h4;
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam logic [14:0] BAUD_ASCII = 15'h0960;
	localparam logic [14:0] BAUD_RTU = 15'h2580;
	localparam logic [7:0] SW_ADDR_MIN = 8'h01;
	localparam logic [7:0] SW_ADDR_MAX = 8'hf7;
	localparam logic [3:0] BLINKS_MIN = 4'h2;
	localparam logic [3:0] BLINKS_MAX = 4'h8;
	localparam logic [3:0] BLINKS_ADDR_TEST = 4'h5;
	localparam logic [3:0] BLINKS_DATA_TEST = 4'h6;
	localparam logic [15:0] CODE_KERNEL = 16'h0000;
	localparam logic [15:0] CODE_ADDR_TEST = 16'h0503;
	localparam logic [15:0] CODE_DATA_TEST = 16'h0402;
	typedef enum logic [3:0] {
		BAUD_50, BAUD_75, BAUD_110, BAUD_134_5, BAUD_150, BAUD_300, BAUD_600, BAUD_1200,
		BAUD_1800, BAUD_2000, BAUD_2400, BAUD_3600, BAUD_4800, BAUD_7200, BAUD_9600, BAUD_19200
	} psc_baud_t;
	typedef enum logic [1:0] {
		MODE_ASCII, MODE_RTU, MODE_SOFT
	} psc_mode_t;
endpackage

// ---- tb/psc_monitor.sv ----
// Concurrent checks on the panel block ports.
`timescale 1ns/1ps
module psc_monitor (
	input wire logic mclk,
	input wire logic rst,
	input wire logic diag_passed,
	input wire logic ctrl_running,
	input wire logic battery_low,
	input wire logic serial1_active,
	input wire logic serial2_active,
	input wire logic kernel_mode,
	input wire logic [7:0] soft_addr,
	input wire logic led_ready,
	input wire logic led_run,
	input wire logic led_battery,
	input wire logic led_serial,
	input wire logic led_net,
	input wire logic led_protect,
	input wire logic mem_protect,
	input wire logic [1:0] port_mode,
	input wire logic [3:0] port_baud,
	input wire logic port_parity_en,
	input wire logic port_parity_odd,
	input wire logic port_data8,
	input wire logic port_stop2,
	input wire logic [6:0] node_addr,
	input wire logic addr_invalid,
	input wire logic soft_cfg_reject
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	AST_READY: assert property (1'b1 |-> led_ready == $past(diag_passed)) else $error("ready lamp wrong");
	AST_BATT: assert property ($rose(battery_low) |=> $rose(led_battery)) else $error("battery lamp late");
	AST_SERIAL: assert property (serial1_active || serial2_active |=> led_serial) else $error("serial lamp off");
	AST_NET: assert property (addr_invalid && $past(addr_invalid) |-> led_net) else $error("net lamp not steady");
	AST_NODE: assert property (addr_invalid |-> node_addr == 7'h00) else $error("invalid node address");
	AST_RANGE: assert property (node_addr != 7'h00 |-> !addr_invalid && node_addr <= 7'h40) else $error("range");
	AST_PROTECT: assert property (1'b1 |-> led_protect == mem_protect) else $error("protect lamp wrong");
	AST_ASCII: assert property (port_mode == 2'h0 |-> {port_baud, port_parity_en, port_parity_odd, port_data8,
		port_stop2} == {psc_pkg::BAUD_2400, 4'h8}) else $error("ascii framing wrong");
	AST_RTU: assert property (port_mode == 2'h1 |-> {port_baud, port_parity_en, port_parity_odd, port_data8,
		port_stop2} == {psc_pkg::BAUD_9600, 4'ha}) else $error("rtu framing wrong");
	AST_BLINK: assert property ($rose(led_run) && !ctrl_running && !$past(ctrl_running) |-> led_run[*3] ##1 !led_run)
		else $error("blink length wrong");
	AST_REJECT: assert property ((soft_addr == 8'h00 || soft_addr > 8'hf7) ##1 port_mode == 2'h2 |-> soft_cfg_reject)
		else $error("bad address taken");
	cover property (kernel_mode && $rose(led_run));
	cover property ($rose(addr_invalid));
	cover property ($rose(soft_cfg_reject));
endmodule // psc_monitor
bind psc_panel psc_monitor u_mon (.mclk(mclk), .rst(rst), .diag_passed(diag_passed), .ctrl_running(ctrl_running),
	.battery_low(battery_low), .serial1_active(serial1_active), .serial2_active(serial2_active),
	.kernel_mode(kernel_mode), .soft_addr(soft_addr), .led_ready(led_ready), .led_run(led_run),
	.led_battery(led_battery), .led_serial(led_serial), .led_net(led_net), .led_protect(led_protect),
	.mem_protect(mem_protect), .port_mode(port_mode), .port_baud(port_baud), .port_parity_en(port_parity_en),
	.port_parity_odd(port_parity_odd), .port_data8(port_data8), .port_stop2(port_stop2),
	.node_addr(node_addr), .addr_invalid(addr_invalid), .soft_cfg_reject(soft_cfg_reject));

// ---- tb/psc_operator.sv ----
// Operator switch model: slide and rotary contacts that bounce on every move.
`timescale 1ns/1ps
module psc_operator (
	input wire logic mclk,
	input wire logic [11:0] want,
	output logic [11:0] sw
);
	logic [11:0] held = 12'h000;
	int cnt = 0;
	initial sw = 12'h000;
	always @(posedge mclk) begin
		if (want !== held) begin
			held = want;
			cnt = 3;
		end
		#1;
		sw = (cnt % 2 == 1) ? ~held : held;
		if (cnt > 0) cnt--;
	end
endmodule // psc_operator

// ---- tb/tb.sv ----
// Self-checking bench for the panel block.
`timescale 1ns/1ps
module tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic diag_passed = 0, ctrl_running = 0, battery_low = 0, serial1_active = 0, serial2_active = 0;
	logic net_active = 0, net_error = 0, fatal_error = 0, kernel_mode = 0, mem_addr_fail = 0, mem_data_fail = 0;
	logic soft_parity_en = 0, soft_parity_odd = 0, soft_data8 = 0, soft_stop2 = 0;
	logic [3:0] fatal_blinks = 4'h2, soft_baud = 4'h0;
	logic [7:0] soft_addr = 8'h01, port_addr, e, a, frm;
	logic [11:0] want = 12'h000, sw;
	logic led_ready, led_run, led_battery, led_serial, led_net, led_net_error, led_protect, mem_protect;
	logic bridge_mode, port_parity_en, port_parity_odd, port_data8, port_stop2, addr_invalid, soft_cfg_reject;
	logic [1:0] port_mode;
	logic [3:0] port_baud;
	logic [6:0] node_addr;
	logic [15:0] error_code, r;
	logic [31:0] seed = 32'hc326;
	int error_cnt = 0, check_count = 0;
	always #5 mclk = ~mclk;
	assign frm = {port_baud, port_parity_en, port_parity_odd, port_data8, port_stop2};
	psc_panel #(.DEBOUNCE_CYC(4), .BLINK_ON_CYC(3), .BLINK_PAUSE_CYC(10)) DUT (.mclk(mclk), .rst(rst),
		.protect_slide(sw[11:10]), .comm_slide(sw[9:8]), .address_tens_switch(sw[7:4]),
		.address_ones_switch(sw[3:0]), .diag_passed(diag_passed), .ctrl_running(ctrl_running),
		.battery_low(battery_low), .serial1_active(serial1_active), .serial2_active(serial2_active),
		.net_active(net_active), .net_error(net_error), .fatal_error(fatal_error), .fatal_blinks(fatal_blinks),
		.kernel_mode(kernel_mode), .mem_addr_fail(mem_addr_fail), .mem_data_fail(mem_data_fail),
		.soft_parity_en(soft_parity_en), .soft_parity_odd(soft_parity_odd), .soft_data8(soft_data8),
		.soft_stop2(soft_stop2), .soft_baud(soft_baud), .soft_addr(soft_addr), .led_ready(led_ready),
		.led_run(led_run), .led_battery(led_battery), .led_serial(led_serial), .led_net(led_net),
		.led_net_error(led_net_error), .led_protect(led_protect), .mem_protect(mem_protect),
		.port_mode(port_mode), .bridge_mode(bridge_mode), .port_baud(port_baud), .port_parity_en(port_parity_en),
		.port_parity_odd(port_parity_odd), .port_data8(port_data8), .port_stop2(port_stop2),
		.port_addr(port_addr), .node_addr(node_addr), .addr_invalid(addr_invalid),
		.soft_cfg_reject(soft_cfg_reject), .error_code(error_code));
	psc_operator OP (.mclk(mclk), .want(want), .sw(sw));
	function logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	function logic [7:0] exp_addr(input logic [7:0] s);
		logic [7:0] v;
		v = 8'(s[7:4]) * 8'h0a + 8'(s[3:0]);
		return (s[3:0] > 4'h9 || v == 8'h00 || v > 8'h40) ? 8'h00 : v;
	endfunction
	task step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task conclude();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task blink(input int n, input int win, input bit pz);
		int c;
		logic l;
		c = 1;
		for (int k = 0; k < 20 && !led_run; k++) step(1);
		l = 1'b1;
		for (int k = 1; k < win; k++) begin
			step(1);
			c += (led_run && !l);
			l = led_run;
		end
		chk(16'(c), 16'(n));
		c = 0;
		for (int k = 0; k < 6 && pz; k++) begin
			step(1);
			c += (led_run && !l);
			l = led_run;
		end
		chk(16'(c), 16'h0000);
		{fatal_error, kernel_mode, mem_addr_fail, mem_data_fail} = 4'h0;
		for (int k = 0; k < 100 && led_run; k++) step(1);
		step(20);
		chk(led_run, 1'b0);
	endtask
	initial begin
		repeat (10000) @(posedge mclk);
		error_cnt++;
		conclude();
	end
	initial begin
		step(12);
		rst = 1'b0;
		want = 12'h011;
		step(20);
		for (int i = 0; i < 40; i++) begin
			r = rnd();
			{diag_passed, ctrl_running, battery_low, serial1_active, serial2_active, net_active, net_error} = r[6:0];
			step(2);
			chk(led_ready, r[6]);
			chk(led_run, r[5]);
			chk(led_battery, r[4]);
			chk(led_serial, r[3] | r[2]);
			chk(led_net, r[1]);
			chk(led_net_error, r[0]);
		end
		{ctrl_running, net_active} = 2'b00;
		$display("status test done");
		e = 8'h0b;
		for (int i = 0; i < 20; i++) begin
			r = rnd();
			a = (i < 10) ? 8'(80'h00016465699930_5c60 >> (8 * (9 - i))) : r[7:0];
			want[7:0] = a;
			step(3);
			chk(node_addr, e[6:0]);
			step(17);
			e = exp_addr(a);
			chk(node_addr, e[6:0]);
			chk(addr_invalid, e == 8'h00);
			chk(led_net, e == 8'h00);
			chk(port_addr, e);
		end
		$display("address test done");
		for (int p = 0; p < 4; p++) begin
			want[11:10] = 2'(p);
			step(20);
			chk(mem_protect, p == 0);
			chk(led_protect, p == 0);
		end
		for (int c = 0; c < 4; c++) begin
			want[9:8] = 2'(c);
			step(20);
			chk(port_mode, (c > 1) ? 2'h2 : 2'(c));
			chk(bridge_mode, c < 2);
			if (c == 0) chk(frm, {psc_pkg::BAUD_2400, 4'h8});
			if (c == 1) chk(frm, {psc_pkg::BAUD_9600, 4'ha});
		end
		$display("slide test done");
		for (int i = 0; i < 14; i++) begin
			r = rnd();
			{soft_baud, soft_parity_en, soft_parity_odd, soft_data8, soft_stop2} = r[7:0];
			soft_addr = (i == 0) ? 8'h01 : (i == 1) ? 8'hf7 : (i > 11) ? 8'(i - 12) * 8'hf8 : 8'h01 + r[15:8] % 8'hf7;
			step(3);
			chk(soft_cfg_reject, i > 11);
			if (i < 12) chk(port_addr, soft_addr);
			if (i < 12) e = r[7:0];
			chk(frm, e);
		end
		soft_addr = 8'h01;
		want[9:8] = 2'h0;
		step(20);
		$display("software framing test done");
		{mem_addr_fail, mem_data_fail} = 2'b11;
		step(2);
		chk(error_code, 16'h0503);
		blink(5, 34, 1'b1);
		mem_data_fail = 1'b1;
		step(2);
		chk(error_code, 16'h0402);
		blink(6, 40, 1'b1);
		for (int i = 0; i < 5; i++) begin
			fatal_blinks = 4'(20'h79182 >> (4 * i));
			fatal_error = 1'b1;
			e = (fatal_blinks < 4'h2) ? 8'h02 : (fatal_blinks > 4'h8) ? 8'h08 : 8'(fatal_blinks);
			blink(int'(e), 6 * int'(e) + 4, 1'b1);
		end
		kernel_mode = 1'b1;
		step(2);
		chk(error_code, 16'h0000);
		blink(10, 60, 1'b0);
		$display("blink test done");
		conclude();
	end
endmodule // tb
